// File: rtl/cycle_timer.sv
`default_nettype none

module cycle_timer #(
   parameter int W = 3
) (
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Control.
   input wire logic i_load,
   input wire logic [W-1:0] i_load_val,
   input wire logic i_step,
   // Status.
   output logic o_active,
   output logic o_expire
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic active_ff;
   logic nxt_active;

   // A reload wins over the count, so a fresh load always restarts the full span.
   always_comb
   begin
      nxt_cnt = cnt_ff;
      o_expire = 1'b0;
      if (i_load)
      begin
         nxt_cnt = i_load_val; // [RULE18]
      end
      else if (i_step && (cnt_ff != '0))
      begin
         nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
         o_expire = (cnt_ff == {{(W-1){1'b0}}, 1'b1});
      end
      nxt_active = (nxt_cnt != '0);
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cnt_ff <= '0;
         active_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         active_ff <= nxt_active;
      end
   end

   assign o_active = active_ff;

endmodule : cycle_timer

`default_nettype wire

// File: rtl/nvm_access_ctrl.sv
`default_nettype none

module nvm_access_ctrl
   import nvm_pkg::*;
#(
   parameter int ATOMIC_CYCLES = ATOMIC_RC_CYCLES,
   parameter int SPLIT_CYCLES = SPLIT_RC_CYCLES
) (
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // CPU I/O register port.
   input wire io_req_t i_io,
   output logic [7:0] o_io_rdata,
   // CPU core status and control.
   input wire logic i_global_irq_en,
   input wire logic i_self_prog_busy,
   output logic o_cpu_halt,
   output logic o_ready_irq,
   // Calibrated RC oscillator, asynchronous to the CPU clock.
   input wire logic i_rc_osc
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state.

   logic [ADDR_W-1:0] addr_ff;
   logic [ADDR_W-1:0] nxt_addr;
   logic [7:0] data_ff;
   logic [7:0] nxt_data;
   prog_mode_t mode_ff;
   prog_mode_t nxt_mode;
   prog_mode_t run_mode_ff;
   prog_mode_t nxt_run_mode;
   logic irq_en_ff;
   logic nxt_irq_en;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic irq_ff;
   logic nxt_irq;
   logic [7:0] mem [MEM_DEPTH];

   logic arm_active;
   logic busy;
   logic prog_expire;
   logic halt_active;

   ////////////////////////////////////////////////////////////////////////////
   // RC oscillator synchroniser and edge detect.

   logic rc_meta_ff;
   logic rc_sync_ff;
   logic rc_prev_ff;
   logic rc_tick;

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rc_meta_ff <= 1'b0;
         rc_sync_ff <= 1'b0;
         rc_prev_ff <= 1'b0;
      end
      else
      begin
         rc_meta_ff <= i_rc_osc;
         rc_sync_ff <= rc_meta_ff;
         rc_prev_ff <= rc_sync_ff;
      end
   end

   // The oscillator must run well below half the CPU clock or ticks are lost.
   assign rc_tick = rc_sync_ff && !rc_prev_ff; // [RULE14]

   ////////////////////////////////////////////////////////////////////////////
   // Access decode.

   logic ctrl_wr;
   logic arm_load;
   logic write_start;
   logic read_start;
   logic halt_load;
   logic [ARM_W-1:0] halt_val;
   logic [PROG_CNT_W-1:0] prog_val;

   always_comb
   begin
      ctrl_wr = i_io.wr && (i_io.addr == ADDR_CTRL);
      arm_load = ctrl_wr && i_io.wdata[BIT_ARM]; // [RULE3]
      // Arm must already be set; arm and strobe in one write does not count.
      write_start = ctrl_wr && i_io.wdata[BIT_WRITE] && arm_active // [RULE1] [RULE2]
                    && !busy && !i_self_prog_busy // [RULE10]
                    && (mode_ff != MODE_RSVD); // [RULE15]
      read_start = ctrl_wr && i_io.wdata[BIT_READ] && !busy; // [RULE6] [RULE9]
      halt_load = write_start || read_start;
      halt_val = read_start ? READ_HALT_CYCLES : WRITE_HALT_CYCLES; // [RULE5] [RULE8]
      if (mode_ff == MODE_ATOMIC)
      begin
         prog_val = PROG_CNT_W'(ATOMIC_CYCLES); // [RULE14] [RULE15]
      end
      else
      begin
         prog_val = PROG_CNT_W'(SPLIT_CYCLES); // [RULE15]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timers: arm window, CPU halt, programming time.

   cycle_timer #(
      .W(ARM_W)
   ) u_arm_timer (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_load(arm_load),
      .i_load_val(ARM_WINDOW_CYCLES),
      .i_step(1'b1),
      .o_active(arm_active),
      .o_expire()
   ); // [RULE3] [RULE18]

   cycle_timer #(
      .W(ARM_W)
   ) u_halt_timer (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_load(halt_load),
      .i_load_val(halt_val),
      .i_step(1'b1),
      .o_active(halt_active),
      .o_expire()
   ); // [RULE5] [RULE8]

   cycle_timer #(
      .W(PROG_CNT_W)
   ) u_prog_timer (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_load(write_start),
      .i_load_val(prog_val),
      .i_step(rc_tick),
      .o_active(busy),
      .o_expire(prog_expire)
   ); // [RULE4] [RULE14]

   ////////////////////////////////////////////////////////////////////////////
   // Register next state.

   logic mem_we;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rd_byte;

   always_comb
   begin
      nxt_addr = addr_ff;
      nxt_data = data_ff;
      nxt_mode = mode_ff;
      nxt_run_mode = run_mode_ff;
      nxt_irq_en = irq_en_ff;
      nxt_rdata = 8'h00;
      mem_rd_byte = mem[addr_ff];
      if (i_io.wr && (i_io.addr == ADDR_ADDR_LO) && !busy)
      begin
         nxt_addr[7:0] = i_io.wdata; // [RULE9]
      end
      if (i_io.wr && (i_io.addr == ADDR_ADDR_HI) && !busy)
      begin
         nxt_addr[8] = i_io.wdata[0]; // [RULE9]
      end
      if (i_io.wr && (i_io.addr == ADDR_DATA))
      begin
         nxt_data = i_io.wdata;
      end
      if (ctrl_wr)
      begin
         nxt_irq_en = i_io.wdata[BIT_IRQ_EN];
         if (!busy)
         begin
            nxt_mode = prog_mode_t'(i_io.wdata[BIT_MODE_HI:BIT_MODE_LO]); // [RULE16]
         end
      end
      if (write_start)
      begin
         nxt_run_mode = mode_ff; // [RULE15]
      end
      // A read overrides a same-cycle data write: the fetched byte lands last.
      if (read_start)
      begin
         nxt_data = mem_rd_byte; // [RULE7]
      end
      if (i_io.rd)
      begin
         case (i_io.addr)
            ADDR_CTRL:
            begin
               nxt_rdata = {2'b00, mode_ff, irq_en_ff, arm_active, busy, 1'b0}; // [RULE4]
            end
            ADDR_DATA:
            begin
               nxt_rdata = data_ff;
            end
            ADDR_ADDR_LO:
            begin
               nxt_rdata = addr_ff[7:0];
            end
            ADDR_ADDR_HI:
            begin
               nxt_rdata = {7'h00, addr_ff[8]};
            end
            default:
            begin
               nxt_rdata = 8'h00;
            end
         endcase
      end
      nxt_irq = irq_en_ff && i_global_irq_en && !busy && !i_self_prog_busy; // [RULE17]
      // The byte is committed only when the full programming time has run out.
      mem_we = prog_expire; // [RULE4]
      case (run_mode_ff)
         MODE_ATOMIC:
         begin
            mem_wdata = data_ff;
         end
         MODE_ERASE:
         begin
            mem_wdata = ERASED_BYTE;
         end
         MODE_WRITE:
         begin
            mem_wdata = mem_rd_byte & data_ff;
         end
         default:
         begin
            mem_wdata = mem_rd_byte;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         addr_ff <= ADDR_RESET;
         data_ff <= DATA_RESET;
         mode_ff <= MODE_ATOMIC;
         run_mode_ff <= MODE_ATOMIC;
         irq_en_ff <= 1'b0;
         rdata_ff <= 8'h00;
         irq_ff <= 1'b0;
      end
      else
      begin
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         mode_ff <= nxt_mode;
         run_mode_ff <= nxt_run_mode;
         irq_en_ff <= nxt_irq_en;
         rdata_ff <= nxt_rdata;
         irq_ff <= nxt_irq;
      end
   end

   // The array is not reset: its contents are meant to outlive any reset.
   always_ff @(posedge i_sys_clk)
   begin
      if (mem_we)
      begin
         mem[addr_ff] <= mem_wdata; // [RULE1]
      end
   end

   assign o_io_rdata = rdata_ff;
   assign o_cpu_halt = halt_active;
   assign o_ready_irq = irq_ff;

endmodule : nvm_access_ctrl

`default_nettype wire

// File: rtl/nvm_pkg.sv
// Behaviour
// [RULE1] Arm bit set, strobe within four cycles: program data byte at address.
// [RULE2] Strobe written while arm bit is clear is ignored; nothing is programmed.
// [RULE3] Arm bit written to one clears itself four cycles later.
// [RULE4] Write strobe reads one while programming, cleared by hardware when done.
// [RULE5] Accepted write strobe stalls the CPU for two cycles.
// [RULE6] Writing one to the read strobe starts a read at the loaded address.
// [RULE7] Read completes at once; byte is in the data register right after.
// [RULE8] Every read stalls the CPU for four cycles.
// [RULE9] During a write, reads are refused and address writes ignored.
// [RULE10] No programming starts while the CPU is writing flash.
// [RULE11] Software waits idle, loads address and data, arms, then strobes in time.
// [RULE12] Software keeps interrupts off through the arm and strobe sequence.
// [RULE13] Software checks the busy strobe is zero before reading.
// [RULE14] Write time is counted in calibrated RC oscillator cycles, 26,368.
// [RULE15] Mode field picks atomic, erase only, write only; 11 is reserved.
// [RULE16] Writes to the mode field are ignored while the write strobe is set.
// [RULE17] Ready interrupt is a level while idle, enabled, and global enable on; the code also holds it low while i_self_prog_busy is set.
// [RULE18] Each new arm write restarts the four-cycle window from zero.
`default_nettype none

package nvm_pkg;

   // I/O register addresses.
   localparam logic [5:0] ADDR_CTRL = 6'h1F;
   localparam logic [5:0] ADDR_DATA = 6'h20;
   localparam logic [5:0] ADDR_ADDR_LO = 6'h21;
   localparam logic [5:0] ADDR_ADDR_HI = 6'h22;

   // Control register bit positions.
   localparam int BIT_READ = 0;
   localparam int BIT_WRITE = 1;
   localparam int BIT_ARM = 2;
   localparam int BIT_IRQ_EN = 3;
   localparam int BIT_MODE_LO = 4;
   localparam int BIT_MODE_HI = 5;

   // Array geometry.
   localparam int ADDR_W = 9;
   localparam int MEM_DEPTH = 512;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;

   // CPU clock timing.
   localparam int SYS_CLK_MHZ = 100;
   localparam int ARM_W = 3;
   localparam logic [ARM_W-1:0] ARM_WINDOW_CYCLES = 3'h4;
   localparam logic [ARM_W-1:0] WRITE_HALT_CYCLES = 3'h2;
   localparam logic [ARM_W-1:0] READ_HALT_CYCLES = 3'h4;

   // Programming time in calibrated RC oscillator cycles.
   localparam int PROG_CNT_W = 15;
   localparam int ATOMIC_TIME_US = 3400;
   localparam int SPLIT_TIME_US = 1800;
   localparam int ATOMIC_RC_CYCLES = 26368;
   localparam int SPLIT_RC_CYCLES = (ATOMIC_RC_CYCLES * SPLIT_TIME_US) / ATOMIC_TIME_US;

   // Reset values.
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;

   typedef enum logic [1:0]
   {
      MODE_ATOMIC = 2'b00,
      MODE_ERASE = 2'b01,
      MODE_WRITE = 2'b10,
      MODE_RSVD = 2'b11
   } prog_mode_t;

   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } io_req_t;

endpackage : nvm_pkg

`default_nettype wire

// File: tb/nvm_access_ctrl_checker.sv
`default_nettype none
module nvm_access_ctrl_checker
   import nvm_pkg::*;
#(
   parameter int ATOMIC_CYCLES = 5,
   parameter int SPLIT_CYCLES = 3
) (
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Watched ports.
   input wire io_req_t i_io,
   input wire logic [7:0] o_io_rdata,
   input wire logic i_global_irq_en,
   input wire logic i_self_prog_busy,
   input wire logic o_cpu_halt,
   input wire logic o_ready_irq,
   input wire logic i_rc_osc
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_b);
   // Age of the last arm write; it saturates so an old arm never looks live again.
   logic [2:0] age_ff;
   logic [2:0] nxt_age;
   logic cw;
   logic cr;
   logic strb;
   assign cw = i_io.wr && i_io.addr == ADDR_CTRL;
   assign cr = i_io.rd && i_io.addr == ADDR_CTRL;
   assign strb = cw && i_io.wdata[1:0] == 2'h2;
   always_comb
   begin
      nxt_age = (age_ff == 3'h7) ? age_ff : age_ff + 3'h1;
      if (cw && i_io.wdata[BIT_ARM])
      begin
         nxt_age = 3'h1;
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         age_ff <= 3'h7;
      end
      else
      begin
         age_ff <= nxt_age;
      end
   end
   ////////////////////////////////////////
   property p_arm_on;
      cr && age_ff <= ARM_WINDOW_CYCLES |=> o_io_rdata[BIT_ARM];
   endproperty
   a_arm_on: assert property (p_arm_on) else $error("arm low in window");
   property p_arm_off;
      cr && age_ff > ARM_WINDOW_CYCLES |=> !o_io_rdata[BIT_ARM];
   endproperty
   a_arm_off: assert property (p_arm_off) else $error("arm high late");
   property p_no_arm;
      strb && age_ff > ARM_WINDOW_CYCLES |=> !$rose(o_cpu_halt);
   endproperty
   a_no_arm: assert property (p_no_arm) else $error("unarmed strobe taken");
   property p_sp_block;
      strb && i_self_prog_busy |=> !$rose(o_cpu_halt);
   endproperty
   a_sp_block: assert property (p_sp_block) else $error("strobe during flash write");
   property p_halt_src;
      $rose(o_cpu_halt) |-> $past(cw && i_io.wdata[1:0] != 2'h0);
   endproperty
   a_halt_src: assert property (p_halt_src) else $error("halt without strobe");
   property p_wr_halt;
      $rose(o_cpu_halt) && $past(strb) |-> o_cpu_halt [*2] ##1 !o_cpu_halt;
   endproperty
   a_wr_halt: assert property (p_wr_halt) else $error("write halt length");
   property p_rd_halt;
      $rose(o_cpu_halt) && $past(cw && i_io.wdata[BIT_READ]) |-> o_cpu_halt [*4] ##1 !o_cpu_halt;
   endproperty
   a_rd_halt: assert property (p_rd_halt) else $error("read halt length");
   property p_irq_gate;
      o_ready_irq |-> $past(i_global_irq_en && !i_self_prog_busy);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
   property p_irq_busy;
      $rose(o_cpu_halt) && $past(strb) |=> !o_ready_irq [*2];
   endproperty
   a_irq_busy: assert property (p_irq_busy) else $error("irq during write");
endmodule : nvm_access_ctrl_checker
bind nvm_access_ctrl nvm_access_ctrl_checker #(
   .ATOMIC_CYCLES(ATOMIC_CYCLES),
   .SPLIT_CYCLES(SPLIT_CYCLES)
) u_chk (
   .i_sys_clk, .i_rst_b, .i_io, .o_io_rdata, .i_global_irq_en, .i_self_prog_busy,
   .o_cpu_halt, .o_ready_irq, .i_rc_osc
);
`default_nettype wire

// File: tb/nvm_access_ctrl_tb.sv
`default_nettype none
module nvm_access_ctrl_tb
   import nvm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_sys_clk = 1'b0;
   logic i_rst_b = 1'b0;
   io_req_t i_io = '0;
   logic [7:0] o_io_rdata;
   logic i_global_irq_en = 1'b0;
   logic i_self_prog_busy = 1'b0;
   logic o_cpu_halt;
   logic o_ready_irq;
   logic i_rc_osc = 1'b0;
   logic [7:0] cb = 8'h00;
   int polls;
   int errors = 0;
   int n_compared = 0;
   always #5 i_sys_clk = ~i_sys_clk;
   // Slow enough for the synchroniser to see every oscillator edge.
   always #50 i_rc_osc = ~i_rc_osc;
   nvm_access_ctrl #(.ATOMIC_CYCLES(5), .SPLIT_CYCLES(3)) uut (.i_sys_clk, .i_rst_b, .i_io,
      .o_io_rdata, .i_global_irq_en, .i_self_prog_busy, .o_cpu_halt, .o_ready_irq, .i_rc_osc);
   ////////////////////////////////////////
   task automatic end_sim;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_io <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge i_sys_clk);
      i_io <= '0;
      #1;
   endtask : acc
   task automatic halts(input int exp);
      int n;
      n = 0;
      repeat (8)
      begin
         n += (o_cpu_halt === 1'b1);
         @(posedge i_sys_clk);
         #1;
      end
      chk(n[7:0], exp[7:0]);
   endtask : halts
   task automatic drv(input logic g, input logic s);
      @(posedge i_sys_clk);
      i_global_irq_en <= g;
      i_self_prog_busy <= s;
      repeat (3) @(posedge i_sys_clk);
      #1;
   endtask : drv
   task automatic wait_idle;
      polls = 0;
      do
      begin
         acc(1'b0, ADDR_CTRL, 8'h00);
         polls++;
      end
      while (o_io_rdata[BIT_WRITE] !== 1'b0 && polls < 200);
      if (o_io_rdata[BIT_WRITE] !== 1'b0)
      begin
         errors++;
         end_sim();
      end
   endtask : wait_idle
   task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m,
      input logic ok);
      acc(1'b1, ADDR_ADDR_LO, a[7:0]);
      acc(1'b1, ADDR_ADDR_HI, {7'h00, a[8]});
      acc(1'b1, ADDR_DATA, d);
      // Arm and strobe go back to back, so nothing can slip in between them.
      acc(1'b1, ADDR_CTRL, {2'h0, m, 4'h4} | cb);
      acc(1'b1, ADDR_CTRL, {2'h0, m, 4'h2} | cb);
      halts(ok ? 2 : 0);
      acc(1'b0, ADDR_CTRL, 8'h00);
      chk(o_io_rdata, {2'h0, m, 2'h0, ok, 1'h0} | cb);
   endtask : prog
   task automatic readb(input logic [8:0] a, input logic [7:0] exp);
      acc(1'b1, ADDR_ADDR_LO, a[7:0]);
      acc(1'b1, ADDR_ADDR_HI, {7'h00, a[8]});
      acc(1'b1, ADDR_CTRL, 8'h01 | cb);
      halts(4);
      acc(1'b0, ADDR_DATA, 8'h00);
      chk(o_io_rdata, exp);
   endtask : readb
   task automatic step(input logic [7:0] d, input logic [1:0] m, input logic ok,
      input logic [7:0] exp);
      prog(9'h105, d, m, ok);
      wait_idle();
      readb(9'h105, exp);
   endtask : step
   ////////////////////////////////////////
   task automatic s_modes;
      step(8'h3C, MODE_ATOMIC, 1'b1, 8'h3C);
      // Five oscillator ticks span 16 to 21 polls; three ticks span 6 to 11.
      chk({7'h00, polls >= 14 && polls <= 24}, 8'h01);
      step(8'h3C, MODE_ERASE, 1'b1, 8'hFF);
      chk({7'h00, polls >= 4 && polls <= 13}, 8'h01);
      step(8'hA5, MODE_WRITE, 1'b1, 8'hA5);
      step(8'h0F, MODE_WRITE, 1'b1, 8'h05);
      step(8'h00, MODE_RSVD, 1'b0, 8'h05);
   endtask : s_modes
   task automatic s_busy;
      prog(9'h0F0, 8'h77, MODE_ATOMIC, 1'b1);
      acc(1'b1, ADDR_ADDR_LO, 8'h11);
      acc(1'b1, ADDR_CTRL, 8'h31);
      halts(0);
      acc(1'b0, ADDR_CTRL, 8'h00);
      chk(o_io_rdata, 8'h02);
      wait_idle();
      acc(1'b0, ADDR_ADDR_LO, 8'h00);
      chk(o_io_rdata, 8'hF0);
      acc(1'b0, ADDR_DATA, 8'h00);
      chk(o_io_rdata, 8'h77);
      readb(9'h0F0, 8'h77);
   endtask : s_busy
   task automatic s_arm;
      acc(1'b1, ADDR_CTRL, 8'h02);
      halts(0);
      acc(1'b1, ADDR_CTRL, 8'h04);
      acc(1'b0, ADDR_CTRL, 8'h00);
      chk(o_io_rdata, 8'h04);
      repeat (4) @(posedge i_sys_clk);
      acc(1'b0, ADDR_CTRL, 8'h00);
      chk(o_io_rdata, 8'h00);
      acc(1'b1, ADDR_CTRL, 8'h02);
      halts(0);
      acc(1'b1, ADDR_CTRL, 8'h04);
      @(posedge i_sys_clk);
      acc(1'b1, ADDR_CTRL, 8'h04);
      acc(1'b1, ADDR_CTRL, 8'h02);
      halts(2);
      wait_idle();
   endtask : s_arm
   task automatic s_irq;
      cb = 8'h08;
      drv(1'b1, 1'b1);
      acc(1'b1, ADDR_CTRL, 8'h0C);
      acc(1'b1, ADDR_CTRL, 8'h0A);
      halts(0);
      chk({7'h00, o_ready_irq}, 8'h00);
      acc(1'b0, ADDR_CTRL, 8'h00);
      chk(o_io_rdata, 8'h08);
      drv(1'b1, 1'b0);
      chk({7'h00, o_ready_irq}, 8'h01);
      prog(9'h0AA, 8'h5A, MODE_ATOMIC, 1'b1);
      chk({7'h00, o_ready_irq}, 8'h00);
      wait_idle();
      drv(1'b1, 1'b0);
      chk({7'h00, o_ready_irq}, 8'h01);
      drv(1'b0, 1'b0);
      chk({7'h00, o_ready_irq}, 8'h00);
      cb = 8'h00;
   endtask : s_irq
   initial
   begin
      repeat (2) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      s_modes();
      s_busy();
      s_arm();
      s_irq();
      end_sim();
   end
endmodule : nvm_access_ctrl_tb
`default_nettype wire
